// ### stk_map.svh
// Purpose: Constants for the timekeeper SRAM bus controller.
// Assumes: 125 MHz mclk, 8 ns period.
// Notes:   Times are in ns; cycle counts derive from them.
`ifndef STK_MAP_SVH
`define STK_MAP_SVH
`define STK_CLK_NS        8
`define STK_PULSE_NS      150
`define STK_RECOVERY_NS   20
`define STK_ACCESS_NS     200
`define STK_PULSE_CYC     ((`STK_PULSE_NS + `STK_CLK_NS - 1) / `STK_CLK_NS)
`define STK_RECOVERY_CYC  ((`STK_RECOVERY_NS + `STK_CLK_NS - 1) / `STK_CLK_NS)
`define STK_ACCESS_CYC    ((`STK_ACCESS_NS + `STK_CLK_NS - 1) / `STK_CLK_NS)
`define STK_PATTERN       64'h5ca3_3ac5_5ca3_3ac5
`define STK_BITS          64
`define STK_ADDR_W        17
`endif

// ### stk_pkg.sv
// Purpose: Types for the timekeeper SRAM bus controller.
// Assumes: Constants come from stk_map.svh.
// Notes:   Pin group travels as one packed struct.
package stk_pkg;
  typedef struct packed {
    logic        chip_sel_n;
    logic        write_strobe_n;
    logic        out_gate_n;
    logic [16:0] byte_address_lines;
    logic [7:0]  data_out;
    logic        data_oe_n;
  } stk_pins_t;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_SETUP = 7'h02,
    ST_PULSE = 7'h04,
    ST_RECOV = 7'h08,
    ST_NEXT  = 7'h10,
    ST_DONE  = 7'h20,
    ST_ABORT = 7'h40
  } stk_state_t;
  typedef enum logic [2:0] {
    PH_OPEN  = 3'h1,
    PH_MATCH = 3'h2,
    PH_XFER  = 3'h4
  } stk_phase_t;
endpackage

// ### stk_host.sv
// Purpose: Host controller that reads or sets the hidden timekeeper.
// Assumes: Device pins are sampled synchronously to mclk.
// Notes:   One request runs open read, 64 unlock writes, 64 transfers.
// How it works
// - Address is held stable through every write access.
// - Write strobe stays high for recovery cycles between accesses.
// - Output gate stays high during writes.
// - Send 64 pattern writes to unlock the timekeeper.
// - Begin each unlock with one read to any location.
// - All unlock writes go to one scratch address.
// - Transfers: reads sample data bit 0, writes drive it.
// - All 64 bits are moved, never partial registers, unless abort_req or a supply drop ends a transfer early.
// - Bits go register 0 bit 0 through register 7 bit 7.
// - Pattern is C5 3A A3 5C twice, least significant bit first.
`timescale 1ns/10ps
`include "stk_map.svh"
module stk_host
(
  input  wire logic                    mclk,       // System clock.
  input  wire logic                    reset_n,    // Sync reset.
  input  wire logic                    req,        // Start request pulse.
  input  wire logic                    req_write,  // One sets the clock.
  input  wire logic [63:0]             wr_regs,    // Registers to write.
  input  wire logic [16:0]             scratch,    // Scratch byte address.
  input  wire logic                    abort_req,  // Abort transfer.
  input  wire logic                    supply_ok,  // Supply in tolerance.
  input  wire logic [7:0]              data_in,    // Data pins in.
  output stk_pkg::stk_pins_t           pins,       // Device pins out.
  output logic                         abort_n,    // Abort pin.
  output logic                         busy,       // Sequence running.
  output logic                         done,       // Done pulse.
  output logic [63:0]                  rd_regs     // Registers read.
);
  // ****************************************************
  // State
  // ****************************************************
  stk_pkg::stk_state_t state, next_state;
  stk_pkg::stk_phase_t phase, next_phase;
  stk_pkg::stk_pins_t  next_pins;
  logic [6:0]  bit_idx, next_bit_idx;
  logic [7:0]  cnt, next_cnt;
  logic        wr_mode, next_wr_mode;
  logic [63:0] shreg, next_shreg;
  logic        next_abort_n, next_busy, next_done;
  logic [63:0] next_rd_regs;
  localparam logic [63:0] PATTERN = `STK_PATTERN;

  function automatic logic is_read(input stk_pkg::stk_phase_t p,
                                   input logic w);
    is_read = (p == stk_pkg::PH_OPEN) || (p == stk_pkg::PH_XFER && !w);
  endfunction

  // ****************************************************
  // Sequencer
  // ****************************************************
  always_comb
  begin
    next_state   = state;
    next_phase   = phase;
    next_pins    = pins;
    next_bit_idx = bit_idx;
    next_cnt     = cnt;
    next_wr_mode = wr_mode;
    next_shreg   = shreg;
    next_abort_n = 1'b1;
    next_busy    = busy;
    next_done    = 1'b0;
    next_rd_regs = rd_regs;
    case (state)
      stk_pkg::ST_IDLE:
      begin
        next_pins.chip_sel_n     = 1'b1;
        next_pins.write_strobe_n = 1'b1;
        next_pins.out_gate_n     = 1'b1;
        next_pins.data_oe_n      = 1'b1;
        if (req && supply_ok)
        begin
          next_phase   = stk_pkg::PH_OPEN;
          next_wr_mode = req_write;
          next_shreg   = wr_regs;
          next_bit_idx = 7'h00;
          next_busy    = 1'b1;
          next_state   = stk_pkg::ST_SETUP;
        end
      end
      stk_pkg::ST_SETUP:
      begin
        next_pins.byte_address_lines = scratch;
        if (is_read(phase, wr_mode))
        begin
          next_pins.chip_sel_n = 1'b0;
          next_pins.out_gate_n = 1'b0;
          next_pins.data_oe_n  = 1'b1;
          next_cnt   = 8'(`STK_ACCESS_CYC);
        end
        else
        begin
          next_pins.out_gate_n = 1'b1;
          next_pins.chip_sel_n = 1'b0;
          next_pins.write_strobe_n = 1'b0;
          next_pins.data_oe_n  = 1'b0;
          next_pins.data_out   = 8'h00;
          next_pins.data_out[0] = (phase == stk_pkg::PH_MATCH) ?
            PATTERN[bit_idx[5:0]] : shreg[bit_idx[5:0]];
          next_cnt   = 8'(`STK_PULSE_CYC);
        end
        next_state = stk_pkg::ST_PULSE;
        // A supply drop here leaves every strobe high and ends the run.
        if (!supply_ok)
        begin
          next_pins  = pins;
          next_state = stk_pkg::ST_ABORT;
        end
      end
      stk_pkg::ST_PULSE:
      begin
        if (!supply_ok)
          next_state = stk_pkg::ST_ABORT;
        else if (abort_req && phase == stk_pkg::PH_XFER)
          next_state = stk_pkg::ST_ABORT;
        else if (cnt > 8'h01)
          next_cnt = cnt - 8'h01;
        else
        begin
          if (is_read(phase, wr_mode) && phase == stk_pkg::PH_XFER)
            next_rd_regs[bit_idx[5:0]] = data_in[0];
          next_pins.write_strobe_n = 1'b1;
          next_pins.chip_sel_n     = 1'b1;
          next_pins.out_gate_n     = 1'b1;
          next_cnt   = 8'(`STK_RECOVERY_CYC);
          next_state = stk_pkg::ST_RECOV;
        end
      end
      stk_pkg::ST_RECOV:
      begin
        next_pins.data_oe_n = 1'b1;
        if (cnt > 8'h01)
          next_cnt = cnt - 8'h01;
        else
          next_state = stk_pkg::ST_NEXT;
      end
      stk_pkg::ST_NEXT:
      begin
        next_state = stk_pkg::ST_SETUP;
        if (phase == stk_pkg::PH_OPEN)
        begin
          next_phase   = stk_pkg::PH_MATCH;
          next_bit_idx = 7'h00;
        end
        else if (bit_idx == 7'(`STK_BITS - 1))
        begin
          next_bit_idx = 7'h00;
          if (phase == stk_pkg::PH_MATCH)
            next_phase = stk_pkg::PH_XFER;
          else
            next_state = stk_pkg::ST_DONE;
        end
        else
          next_bit_idx = bit_idx + 7'h01;
      end
      stk_pkg::ST_DONE:
      begin
        next_done  = 1'b1;
        next_busy  = 1'b0;
        next_state = stk_pkg::ST_IDLE;
      end
      stk_pkg::ST_ABORT:
      begin
        next_pins.chip_sel_n     = 1'b1;
        next_pins.write_strobe_n = 1'b1;
        next_pins.out_gate_n     = 1'b1;
        next_pins.data_oe_n      = 1'b1;
        next_abort_n = !(phase == stk_pkg::PH_XFER);
        next_state   = stk_pkg::ST_DONE;
      end
      default:
        next_state = stk_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state   <= stk_pkg::ST_IDLE;
      phase   <= stk_pkg::PH_OPEN;
      pins    <= '{1'b1, 1'b1, 1'b1, 17'h00000, 8'h00, 1'b1};
      bit_idx <= 7'h00;
      cnt     <= 8'h00;
      wr_mode <= 1'b0;
      shreg   <= 64'h0;
      abort_n <= 1'b1;
      busy    <= 1'b0;
      done    <= 1'b0;
      rd_regs <= 64'h0;
    end
    else
    begin
      state   <= next_state;
      phase   <= next_phase;
      pins    <= next_pins;
      bit_idx <= next_bit_idx;
      cnt     <= next_cnt;
      wr_mode <= next_wr_mode;
      shreg   <= next_shreg;
      abort_n <= next_abort_n;
      busy    <= next_busy;
      done    <= next_done;
      rd_regs <= next_rd_regs;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb_chk @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence s_wr_start;
    !pins.write_strobe_n && $rose(!pins.chip_sel_n);
  endsequence
  chk_write_og_high: assert property (
    !pins.write_strobe_n |-> pins.out_gate_n)
    else $error("output gate low during write");
  chk_addr_stable: assert property (
    !pins.write_strobe_n && $past(!pins.write_strobe_n)
    |-> $stable(pins.byte_address_lines))
    else $error("address moved in write");
  chk_write_width: assert property (
    s_wr_start ##1 (supply_ok && !abort_req) [*8]
    |-> !pins.write_strobe_n)
    else $error("write pulse too short");
  chk_recovery: assert property (
    $rose(pins.write_strobe_n) |-> pins.chip_sel_n [*3])
    else $error("recovery too short");
  chk_read_no_drive: assert property (
    !pins.out_gate_n |-> pins.data_oe_n)
    else $error("host drives during read");
  chk_read_ws_high: assert property (
    !pins.out_gate_n |-> pins.write_strobe_n)
    else $error("strobe low in read");
  chk_match_write: assert property (
    phase == stk_pkg::PH_MATCH && !pins.chip_sel_n
    |-> pins.out_gate_n)
    else $error("read inside pattern phase");
  chk_pattern_bit: assert property (
    phase == stk_pkg::PH_MATCH && !pins.write_strobe_n
    |-> pins.data_out[0] == PATTERN[bit_idx[5:0]])
    else $error("wrong pattern bit");
  chk_supply_idle: assert property (
    !supply_ok && state == stk_pkg::ST_IDLE |=> pins.chip_sel_n)
    else $error("access while supply bad");
  chk_supply_hold: assert property (
    !supply_ok && pins.chip_sel_n |=> pins.chip_sel_n)
    else $error("chip select lowered while supply bad");
endmodule

// ### stk_dev_model.sv
// Purpose: Behavioural model of the timekeeper SRAM on the host's pins.
// Assumes: Host drives the pin struct; no pull on the data lines.
// Notes:   Clock writes land whole when the 64th transfer ends.
`timescale 1ns/10ps
module stk_dev_model
#(
  parameter logic [63:0] INIT_REGS   = 64'h0,
  parameter int          RST_IGN_BIT = 36
)
(
  input  wire stk_pkg::stk_pins_t pins,      // Host pin group.
  input  wire logic               abort_n,   // Abort pin, active low.
  input  wire logic               supply_ok, // Supply in tolerance.
  output logic [7:0]              data_in    // Data lines to host.
);
  localparam logic [63:0] PATTERN = 64'h5ca3_3ac5_5ca3_3ac5;
  logic [7:0]  mem [logic [16:0]];
  logic [63:0] regs = INIT_REGS;
  logic [63:0] shadow;
  logic [7:0]  q = 8'h00;
  logic        armed = 1'b0;
  logic        miss = 1'b0;
  logic        open_clk = 1'b0;
  int          ptr = 0;
  int          cnt = 0;
  wire rd  = !pins.chip_sel_n && pins.write_strobe_n
             && supply_ok;
  wire wr  = !pins.chip_sel_n && !pins.write_strobe_n
             && supply_ok;
  wire drv = rd && !pins.out_gate_n;
  // Released lines show the inverse so a stale value never passes.
  assign data_in = drv ? q : ~q;
  task automatic step();
    cnt++;
    if (cnt == 64)
    begin
      open_clk = 1'b0;
      regs     = shadow;
    end
  endtask
  always @(posedge rd)
  begin
    if (open_clk)
    begin
      q = {7'h00, regs[cnt]};
      step();
    end
    else
    begin
      q = mem.exists(pins.byte_address_lines) ?
          mem[pins.byte_address_lines] : 8'h00;
      armed = 1'b1;
      ptr   = 0;
      miss  = 1'b0;
    end
  end
  // A write ends at the first rising edge of either strobe.
  always @(negedge wr)
  begin
    if (open_clk)
    begin
      shadow[cnt] = pins.data_out[0];
      step();
    end
    else if (supply_ok)
    begin
      mem[pins.byte_address_lines] = pins.data_out;
      if (armed && !miss)
      begin
        if (pins.data_out[0] === PATTERN[ptr])
          ptr++;
        else
          miss = 1'b1;
        if (ptr == 64)
        begin
          open_clk = 1'b1;
          armed    = 1'b0;
          cnt      = 0;
          shadow   = regs;
        end
      end
    end
  end
  always @(negedge abort_n)
  begin
    if (open_clk && !regs[RST_IGN_BIT])
      open_clk = 1'b0;
  end
endmodule

// ### tb_stk_host.sv
// Purpose: Self-checking bench for the timekeeper host controller.
// Assumes: 125 MHz mclk; device model answers on the pins.
// Notes:   One task per scenario; bus monitor counts pin hazards.
`timescale 1ns/10ps
module tb_stk_host;
  localparam logic [63:0] INIT = 64'h9901_0203_0405_0607;
  logic mclk, reset_n, req, req_write, abort_req, supply_ok, abort_n;
  logic busy, done;
  logic [63:0] wr_regs, rd_regs;
  logic [16:0] scratch;
  logic [7:0]  data_in;
  stk_pkg::stk_pins_t pins;
  int mismatches = 0;
  int total_checks = 0;
  int bad_bus = 0;
  int abort_seen = 0;
  stk_host DUT (.mclk(mclk), .reset_n(reset_n), .req(req),
    .req_write(req_write), .wr_regs(wr_regs), .scratch(scratch),
    .abort_req(abort_req), .supply_ok(supply_ok), .data_in(data_in),
    .pins(pins), .abort_n(abort_n), .busy(busy), .done(done),
    .rd_regs(rd_regs));
  stk_dev_model #(.INIT_REGS(INIT)) dev (.pins(pins), .abort_n(abort_n),
    .supply_ok(supply_ok), .data_in(data_in));
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (reset_n)
    begin
      if (!pins.chip_sel_n && !pins.write_strobe_n && !pins.out_gate_n)
        bad_bus++;
      if (!pins.chip_sel_n && pins.byte_address_lines !== scratch)
        bad_bus++;
      if (abort_n === 1'b0)
        abort_seen++;
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic w, input logic [63:0] v);
    @(posedge mclk);
    req       <= 1'b1;
    req_write <= w;
    wr_regs   <= v;
    @(posedge mclk);
    req <= 1'b0;
    for (int i = 0; i < 9000; i++)
    begin
      @(posedge mclk);
      if (done === 1'b1)
        break;
    end
    check({63'h0, done}, 64'h1);
  endtask
  task automatic t_reset();
    check({57'h0, busy, done, abort_n, pins.chip_sel_n,
      pins.write_strobe_n, pins.out_gate_n, pins.data_oe_n},
      64'h1f);
    check(rd_regs, 64'h0);
    $display("reset test done");
  endtask
  task automatic t_rw();
    logic [63:0] v [2];
    logic [63:0] cur;
    v   = '{64'h2412_3115_2359_3045, 64'h2506_3002_0807_0605};
    cur = INIT;
    for (int i = 0; i < 3; i++)
    begin
      run(1'b0, 64'h0);
      check(rd_regs, cur);
      if (i < 2)
      begin
        run(1'b1, v[i]);
        check(dev.regs, v[i]);
        cur = v[i];
      end
      check({63'h0, dev.open_clk}, 64'h0);
    end
    $display("read write test done");
  endtask
  task automatic t_abort();
    @(posedge mclk);
    req       <= 1'b1;
    req_write <= 1'b1;
    wr_regs   <= 64'h1111_1111_1111_1111;
    @(posedge mclk);
    req <= 1'b0;
    for (int i = 0; i < 6000 && dev.open_clk !== 1'b1; i++)
      @(posedge mclk);
    repeat (200) @(posedge mclk);
    abort_req <= 1'b1;
    for (int i = 0; i < 200 && done !== 1'b1; i++)
      @(posedge mclk);
    abort_req <= 1'b0;
    check(dev.regs, 64'h2506_3002_0807_0605);
    check({63'h0, abort_seen > 0}, 64'h1);
    run(1'b0, 64'h0);
    check(rd_regs, 64'h2506_3002_0807_0605);
    $display("abort test done");
  endtask
  task automatic t_supply();
    @(posedge mclk);
    supply_ok <= 1'b0;
    req       <= 1'b1;
    @(posedge mclk);
    req <= 1'b0;
    repeat (40) @(posedge mclk);
    check({62'h0, busy, pins.chip_sel_n}, 64'h1);
    supply_ok <= 1'b1;
    req       <= 1'b1;
    @(posedge mclk);
    req <= 1'b0;
    repeat (100) @(posedge mclk);
    supply_ok <= 1'b0;
    for (int i = 0; i < 100 && done !== 1'b1; i++)
      @(posedge mclk);
    check({62'h0, done, pins.chip_sel_n}, 64'h3);
    supply_ok <= 1'b1;
    $display("supply test done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    reset_n   = 1'b0;
    req       = 1'b0;
    req_write = 1'b0;
    wr_regs   = 64'h0;
    scratch   = 17'h1a5c3;
    abort_req = 1'b0;
    supply_ok = 1'b1;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_rw();
    t_abort();
    t_supply();
    check(64'(bad_bus), 64'h0);
    report_and_stop();
  end
  initial
  begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    report_and_stop();
  end
endmodule
